/* rtl/bridge_corr_pkg.sv */
/*
 Shared constants and types for the bridge and temperature correction block.
 Assumes a 32-bit AXI4-Lite register bus and an 18-bit signed datapath.
*/
package bridge_corr_pkg;
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_BRIDGE_OUT = 8'h08;
	localparam logic [7:0] ADDR_TEMP_OUT = 8'h0C;
	localparam logic [7:0] ADDR_RAW_BRIDGE = 8'h10;
	localparam logic [7:0] ADDR_RAW_TEMP = 8'h14;
	localparam logic [7:0] ADDR_CTRL = 8'h18;
	localparam logic [7:0] ADDR_BM_CFG = 8'h1C;
	localparam logic [7:0] ADDR_TM_CFG = 8'h20;
	localparam logic [1:0] COEF_REGION = 2'h1;
	localparam int COEF_N = 11;
	localparam logic [3:0] CI_GAIN_B = 4'h0;
	localparam logic [3:0] CI_OFFSET_B = 4'h1;
	localparam logic [3:0] CI_TCG = 4'h2;
	localparam logic [3:0] CI_TCO = 4'h3;
	localparam logic [3:0] CI_GAIN_DRIFT_SQ = 4'h4;
	localparam logic [3:0] CI_OFFSET_DRIFT_SQ = 4'h5;
	localparam logic [3:0] CI_BRIDGE_SQ = 4'h6;
	localparam logic [3:0] CI_GAIN_T = 4'h7;
	localparam logic [3:0] CI_OFFSET_T = 4'h8;
	localparam logic [3:0] CI_TEMP_SQ = 4'h9;
	localparam logic [3:0] CI_TSETL = 4'hA;
	localparam logic [7:0] OP_BRIDGE_STORED = 8'hA2;
	localparam logic [7:0] OP_BRIDGE_GIVEN = 8'hA3;
	localparam logic [7:0] OP_TEMP_STORED = 8'hA6;
	localparam logic [7:0] OP_TEMP_GIVEN = 8'hA7;
	localparam int STAT_SAT_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam logic signed [39:0] SAT_HI = 40'sh00_0001_FFFF;
	localparam logic signed [39:0] SAT_LO = 40'shFF_FFFE_0000;
	localparam logic signed [39:0] ONE_Q15 = 40'sh00_0000_8000;
	localparam logic signed [39:0] OUT16_HI = 40'sh00_0000_FFFF;
	localparam logic signed [39:0] TSETL_HI = 40'sh00_0000_FFFF;
	localparam logic signed [39:0] OFFT_HI = 40'sh00_0000_1FFF;
	localparam logic signed [39:0] ZERO40 = 40'sh00_0000_0000;
	localparam logic [15:0] BM_CFG_RST = 16'h0000;
	localparam logic [15:0] TM_CFG_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic temp;
		logic [15:0] cfg;
	} meas_req_t;
	typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_CALC} state_t;
endpackage

/* rtl/bridge_temp_correction.sv */
/*
 Correction datapath with raw measurement command sequencing and AXI4-Lite registers.
 Assumes the ADC returns one auto-zero corrected 18-bit reading per request on this clock.
*/
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Behaviour
// - A2 measures bridge with stored config
// - A3 measures bridge with supplied config
// - A6 measures temperature with stored config
// - A7 measures temperature with supplied config
// - Curve select: parabolic or S-shaped
// - Delta T saturated temperature difference
// - Gain drift factor with saturation
// - Offset corrected sum with saturation
// - Parabolic intermediate clamped non-negative
// - Parabolic output from intermediate
// - S-shaped output uses absolute intermediate
// - Bridge result is unsigned 16-bit
// - Any saturation in the measured channel's calculation sets status bit 0
// - Coefficient inputs bounded on write
// - Temperature intermediate clamped non-negative
// - Temperature output parabolic, 16-bit bound
module bridge_temp_correction (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic meas_req,
	output bridge_corr_pkg::meas_req_t meas_out,
	input wire logic adc_valid,
	input wire logic [17:0] adc_data,
	output logic done
);
	bridge_corr_pkg::state_t state_r;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, meas_req_r, done_r, sat_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, wdata_r;
	logic [3:0] wstrb_r;
	logic [7:0] awaddr_r;
	logic [23:0] cmd_r;
	logic curve_r;
	logic [15:0] bm_cfg_r, tm_cfg_r, bridge_out_r, temp_out_r;
	logic signed [17:0] raw_bridge_r, raw_temp_r;
	logic signed [17:0] coef_r [0:bridge_corr_pkg::COEF_N-1];
	bridge_corr_pkg::meas_req_t meas_out_r;
	logic do_wr, wr_ok, cmd_go;
	logic [31:0] wr_val;
	logic [3:0] wr_idx;
	logic signed [17:0] dt_c, k1_c, k2_c, zb_c, zt_c;
	logic [15:0] b_c, t_c;
	logic fb_c, ft_c;

	function automatic logic [18:0] lim(input logic signed [39:0] v,
			input logic signed [39:0] lo, input logic signed [39:0] hi);
		if (v > hi) begin
			lim = {1'b1, hi[17:0]};
		end else if (v < lo) begin
			lim = {1'b1, lo[17:0]};
		end else begin
			lim = {1'b0, v[17:0]};
		end
	endfunction

	// Widened product, then the shift; rounding is toward minus infinity
	function automatic logic signed [39:0] mul15(input logic signed [17:0] a,
			input logic signed [17:0] b);
		logic signed [39:0] p;
		p = a * b;
		mul15 = p >>> 15;
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		rd_word = 32'h0000_0000;
		if (a[7:6] == bridge_corr_pkg::COEF_REGION) begin
			if (32'(a[5:2]) < bridge_corr_pkg::COEF_N) begin
				rd_word = 32'(coef_r[a[5:2]]);
				rd_word = {{14{rd_word[17]}}, rd_word[17:0]};
			end
		end else begin
			case (a)
				bridge_corr_pkg::ADDR_CMD: rd_word = {8'h00, cmd_r};
				bridge_corr_pkg::ADDR_STATUS: rd_word = {30'h0000_0000, state_r != bridge_corr_pkg::ST_IDLE, sat_r};
				bridge_corr_pkg::ADDR_BRIDGE_OUT: rd_word = {16'h0000, bridge_out_r};
				bridge_corr_pkg::ADDR_TEMP_OUT: rd_word = {16'h0000, temp_out_r};
				bridge_corr_pkg::ADDR_RAW_BRIDGE: rd_word = {{14{raw_bridge_r[17]}}, raw_bridge_r};
				bridge_corr_pkg::ADDR_RAW_TEMP: rd_word = {{14{raw_temp_r[17]}}, raw_temp_r};
				bridge_corr_pkg::ADDR_CTRL: rd_word = {31'h0000_0000, curve_r};
				bridge_corr_pkg::ADDR_BM_CFG: rd_word = {16'h0000, bm_cfg_r};
				bridge_corr_pkg::ADDR_TM_CFG: rd_word = {16'h0000, tm_cfg_r};
				default: rd_word = 32'h0000_0000;
			endcase
		end
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= bridge_corr_pkg::ADDR_TM_CFG
			|| (a[7:6] == bridge_corr_pkg::COEF_REGION && 32'(a[5:2]) < bridge_corr_pkg::COEF_N));
	endfunction

	// Both channels captured, answer not yet given
	assign do_wr = !awready_r && !wready_r && !bvalid_r;
	assign wr_idx = awaddr_r[5:2];

	always_comb begin
		logic [31:0] old, m;
		old = rd_word(awaddr_r);
		m = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
		wr_val = (old & ~m) | (wdata_r & m);
	end

	// A command is refused while busy or with a malformed word
	always_comb begin
		cmd_go = 1'b0;
		wr_ok = mapped(awaddr_r);
		if (awaddr_r == bridge_corr_pkg::ADDR_CMD) begin
			case (wr_val[23:16])
				bridge_corr_pkg::OP_BRIDGE_STORED, bridge_corr_pkg::OP_TEMP_STORED:
					cmd_go = wr_val[15:0] == 16'h0000;
				bridge_corr_pkg::OP_BRIDGE_GIVEN, bridge_corr_pkg::OP_TEMP_GIVEN:
					cmd_go = 1'b1;
				default: cmd_go = 1'b0;
			endcase
			cmd_go = cmd_go && state_r == bridge_corr_pkg::ST_IDLE;
			wr_ok = cmd_go;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			awready_r <= 1'b1;
			awaddr_r <= 8'h00;
		end else if (awvalid && awready_r) begin
			awready_r <= 1'b0;
			awaddr_r <= awaddr;
		end else if (bvalid_r && bready) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wready_r <= 1'b1;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else if (wvalid && wready_r) begin
			wready_r <= 1'b0;
			wdata_r <= wdata;
			wstrb_r <= wstrb;
		end else if (bvalid_r && bready) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bvalid_r <= 1'b0;
			bresp_r <= bridge_corr_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_ok ? bridge_corr_pkg::RESP_OKAY : bridge_corr_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= bridge_corr_pkg::RESP_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_word(araddr);
			rresp_r <= mapped(araddr) ? bridge_corr_pkg::RESP_OKAY : bridge_corr_pkg::RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	// Software settings; the curve bit steers the bridge second-order path
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			curve_r <= 1'b0;
			bm_cfg_r <= bridge_corr_pkg::BM_CFG_RST;
			tm_cfg_r <= bridge_corr_pkg::TM_CFG_RST;
			cmd_r <= 24'h00_0000;
		end else if (do_wr && wr_ok) begin
			case (awaddr_r)
				bridge_corr_pkg::ADDR_CTRL: curve_r <= wr_val[0];
				bridge_corr_pkg::ADDR_BM_CFG: bm_cfg_r <= wr_val[15:0];
				bridge_corr_pkg::ADDR_TM_CFG: tm_cfg_r <= wr_val[15:0];
				bridge_corr_pkg::ADDR_CMD: cmd_r <= wr_val[23:0];
				default: cmd_r <= cmd_r;
			endcase
		end
	end

	// Out-of-range coefficient writes are clamped, never wrapped
	genvar gi;
	for (gi = 0; gi < bridge_corr_pkg::COEF_N; gi++) begin : g_coef
		logic signed [39:0] bound;
		logic [18:0] cl;
		always_comb begin
			bound = bridge_corr_pkg::SAT_HI;
			if (gi == int'(bridge_corr_pkg::CI_TSETL)) begin
				bound = bridge_corr_pkg::TSETL_HI;
			end else if (gi == int'(bridge_corr_pkg::CI_OFFSET_T)) begin
				bound = bridge_corr_pkg::OFFT_HI;
			end
			cl = lim(40'(signed'(wr_val)), -bound, bound);
		end
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				coef_r[gi] <= 18'sh00000;
			end else if (do_wr && wr_ok && awaddr_r[7:6] == bridge_corr_pkg::COEF_REGION
					&& 32'(wr_idx) == gi) begin
				coef_r[gi] <= cl[17:0];
			end
		end
	end

	always_comb begin
		logic [18:0] x;
		logic signed [17:0] a, s, q;
		x = 19'h00000;
		a = 18'sh00000;
		s = 18'sh00000;
		q = 18'sh00000;
		fb_c = 1'b0;
		ft_c = 1'b0;
		x = lim(raw_temp_r - coef_r[bridge_corr_pkg::CI_TSETL], bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		dt_c = x[17:0];
		x = lim(mul15(coef_r[bridge_corr_pkg::CI_GAIN_DRIFT_SQ], dt_c), bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(40'(signed'(x[17:0])) + coef_r[bridge_corr_pkg::CI_TCG], bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(mul15(dt_c, x[17:0]), bridge_corr_pkg::SAT_LO, bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(40'(signed'(x[17:0])) + bridge_corr_pkg::ONE_Q15, bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		k1_c = x[17:0];
		x = lim(mul15(coef_r[bridge_corr_pkg::CI_OFFSET_DRIFT_SQ], dt_c), bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(40'(signed'(x[17:0])) + coef_r[bridge_corr_pkg::CI_TCO], bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(mul15(dt_c, x[17:0]), bridge_corr_pkg::SAT_LO, bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(40'(signed'(x[17:0])) + raw_bridge_r, bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(40'(signed'(x[17:0])) + coef_r[bridge_corr_pkg::CI_OFFSET_B],
			bridge_corr_pkg::SAT_LO, bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		k2_c = x[17:0];
		x = lim(mul15(k1_c, k2_c), bridge_corr_pkg::SAT_LO, bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(mul15(coef_r[bridge_corr_pkg::CI_GAIN_B], x[17:0]), bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		zb_c = x[17:0];
		if (!curve_r) begin
			x = lim(40'(signed'(zb_c)) + bridge_corr_pkg::ONE_Q15, bridge_corr_pkg::ZERO40,
				bridge_corr_pkg::SAT_HI);
			fb_c = fb_c | x[18];
			zb_c = x[17:0];
			a = zb_c;
		end else begin
			a = zb_c[17] ? -zb_c : zb_c;
		end
		x = lim(mul15(coef_r[bridge_corr_pkg::CI_BRIDGE_SQ], a), bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		x = lim(40'(signed'(x[17:0])) + bridge_corr_pkg::ONE_Q15, bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		fb_c = fb_c | x[18];
		s = x[17:0];
		// S-shaped output is re-centred on mid scale; parabolic is not
		x = lim(mul15(zb_c, s) + (curve_r ? bridge_corr_pkg::ONE_Q15 : bridge_corr_pkg::ZERO40),
			bridge_corr_pkg::ZERO40, bridge_corr_pkg::OUT16_HI);
		fb_c = fb_c | x[18];
		b_c = x[15:0];
		x = lim(raw_temp_r + coef_r[bridge_corr_pkg::CI_OFFSET_T], bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		ft_c = ft_c | x[18];
		x = lim(mul15(coef_r[bridge_corr_pkg::CI_GAIN_T], x[17:0]), bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		ft_c = ft_c | x[18];
		x = lim(40'(signed'(x[17:0])) + bridge_corr_pkg::ONE_Q15, bridge_corr_pkg::ZERO40,
			bridge_corr_pkg::SAT_HI);
		ft_c = ft_c | x[18];
		zt_c = x[17:0];
		x = lim(mul15(coef_r[bridge_corr_pkg::CI_TEMP_SQ], zt_c), bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		ft_c = ft_c | x[18];
		x = lim(40'(signed'(x[17:0])) + bridge_corr_pkg::ONE_Q15, bridge_corr_pkg::SAT_LO,
			bridge_corr_pkg::SAT_HI);
		ft_c = ft_c | x[18];
		q = x[17:0];
		x = lim(mul15(zt_c, q), bridge_corr_pkg::ZERO40, bridge_corr_pkg::OUT16_HI);
		ft_c = ft_c | x[18];
		t_c = x[15:0];
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= bridge_corr_pkg::ST_IDLE;
			meas_req_r <= 1'b0;
			meas_out_r <= '0;
			done_r <= 1'b0;
		end else begin
			meas_req_r <= 1'b0;
			done_r <= 1'b0;
			case (state_r)
				bridge_corr_pkg::ST_IDLE: begin
					if (do_wr && cmd_go) begin
						state_r <= bridge_corr_pkg::ST_MEAS;
						meas_req_r <= 1'b1;
						meas_out_r.temp <= wr_val[18];
						case (wr_val[23:16])
							bridge_corr_pkg::OP_BRIDGE_STORED: meas_out_r.cfg <= bm_cfg_r;
							bridge_corr_pkg::OP_TEMP_STORED: meas_out_r.cfg <= tm_cfg_r;
							default: meas_out_r.cfg <= wr_val[15:0];
						endcase
					end
				end
				bridge_corr_pkg::ST_MEAS: begin
					if (adc_valid) begin
						state_r <= bridge_corr_pkg::ST_CALC;
					end
				end
				bridge_corr_pkg::ST_CALC: begin
					state_r <= bridge_corr_pkg::ST_IDLE;
					done_r <= 1'b1;
				end
				default: state_r <= bridge_corr_pkg::ST_IDLE;
			endcase
		end
	end

	// Results; temperature feeds later bridge corrections
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			raw_bridge_r <= 18'sh00000;
			raw_temp_r <= 18'sh00000;
			bridge_out_r <= 16'h0000;
			temp_out_r <= 16'h0000;
			sat_r <= 1'b0;
		end else if (state_r == bridge_corr_pkg::ST_IDLE && do_wr && cmd_go) begin
			sat_r <= 1'b0;
		end else if (state_r == bridge_corr_pkg::ST_MEAS && adc_valid) begin
			if (meas_out_r.temp) begin
				raw_temp_r <= adc_data;
			end else begin
				raw_bridge_r <= adc_data;
			end
		end else if (state_r == bridge_corr_pkg::ST_CALC) begin
			if (meas_out_r.temp) begin
				temp_out_r <= t_c;
				sat_r <= ft_c;
			end else begin
				bridge_out_r <= b_c;
				sat_r <= fb_c;
			end
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign meas_req = meas_req_r;
	assign meas_out = meas_out_r;
	assign done = done_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	stored_bridge_cfg_a: assert property (do_wr && cmd_go
		&& wr_val[23:16] == bridge_corr_pkg::OP_BRIDGE_STORED |=> meas_req
		&& !meas_out.temp && meas_out.cfg == $past(bm_cfg_r)) else $error("A2 config wrong");
	given_bridge_cfg_a: assert property (do_wr && cmd_go
		&& wr_val[23:16] == bridge_corr_pkg::OP_BRIDGE_GIVEN |=> meas_req
		&& !meas_out.temp && meas_out.cfg == $past(wr_val[15:0])) else $error("A3 config wrong");
	stored_temp_cfg_a: assert property (do_wr && cmd_go
		&& wr_val[23:16] == bridge_corr_pkg::OP_TEMP_STORED |=> meas_req
		&& meas_out.temp && meas_out.cfg == $past(tm_cfg_r)) else $error("A6 config wrong");
	given_temp_cfg_a: assert property (do_wr && cmd_go
		&& wr_val[23:16] == bridge_corr_pkg::OP_TEMP_GIVEN |=> meas_req
		&& meas_out.temp && meas_out.cfg == $past(wr_val[15:0])) else $error("A7 config wrong");
	delta_t_value_a: assert property (state_r == bridge_corr_pkg::ST_CALC
		&& 40'(raw_temp_r) - 40'(coef_r[bridge_corr_pkg::CI_TSETL]) <= bridge_corr_pkg::SAT_HI
		&& 40'(raw_temp_r) - 40'(coef_r[bridge_corr_pkg::CI_TSETL]) >= bridge_corr_pkg::SAT_LO
		|-> 40'(dt_c) == 40'(raw_temp_r) - 40'(coef_r[bridge_corr_pkg::CI_TSETL]))
		else $error("delta T wrong");
	parab_nonneg_a: assert property (!curve_r |-> !zb_c[17]) else $error("negative Z");
	temp_inter_a: assert property (!zt_c[17]) else $error("negative ZT");
	sat_clear_a: assert property (meas_req |-> !sat_r [*2]) else $error("sat not cleared");
	sat_report_a: assert property (state_r == bridge_corr_pkg::ST_CALC
		&& (meas_out.temp ? ft_c : fb_c) |=> sat_r && done) else $error("sat lost");
	bridge_store_a: assert property (state_r == bridge_corr_pkg::ST_CALC && !meas_out.temp
		|=> bridge_out_r == $past(b_c)) else $error("bridge result lost");
endmodule // bridge_temp_correction

/* tb/adc_model.sv */
/*
 Converter stand-in for the measurement port: answers each meas_req with one reading.
 Assumes meas_out is valid in the cycle meas_req is high; delay is set by the bench.
*/
`timescale 1ns/1ps
module adc_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic meas_req,
	input wire bridge_corr_pkg::meas_req_t meas_out,
	input wire logic [7:0] delay,
	input wire logic [17:0] bridge_raw,
	input wire logic [17:0] temp_raw,
	output logic adc_valid,
	output logic [17:0] adc_data,
	output bridge_corr_pkg::meas_req_t seen
);
	logic [7:0] cnt_r;
	logic pend_r;

	// Data toggles outside the valid cycle so a stale sample never looks right
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pend_r <= 1'b0;
			cnt_r <= 8'h00;
			adc_valid <= 1'b0;
			adc_data <= 18'h2AAAA;
			seen <= '0;
		end else begin
			adc_valid <= 1'b0;
			adc_data <= ~adc_data;
			if (meas_req) begin
				pend_r <= 1'b1;
				cnt_r <= delay;
				seen <= meas_out;
			end else if (pend_r) begin
				if (cnt_r == 8'h00) begin
					pend_r <= 1'b0;
					adc_valid <= 1'b1;
					adc_data <= seen.temp ? temp_raw : bridge_raw;
				end else begin
					cnt_r <= cnt_r - 8'h01;
				end
			end
		end
	end
endmodule // adc_model

/* tb/bridge_temp_correction_tb.sv */
/*
 Self-checking bench: AXI4-Lite master tasks, command sequences, expected results.
 Assumes the design's AXI4-Lite timing and the converter model in adc_model.sv.
*/
`timescale 1ns/1ps
module bridge_temp_correction_tb;
	logic clock, rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, meas_req, adc_valid, done;
	logic [7:0] awaddr, araddr, dly;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [17:0] adc_data, b_raw, t_raw;
	bridge_corr_pkg::meas_req_t meas_out, seen;
	logic [31:0] d;
	logic [1:0] r;
	logic [31:0] cv [11];
	logic [17:0] pb [3];
	logic [31:0] pe [3];
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;

	bridge_temp_correction dut (.clock, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .meas_req, .meas_out, .adc_valid, .adc_data, .done);

	adc_model adc (.clock, .rst_b, .meas_req, .meas_out, .delay(dly), .bridge_raw(b_raw),
		.temp_raw(t_raw), .adc_valid, .adc_data, .seen);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Whole run is a few hundred cycles; the ceiling leaves ample slack
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish;
		end
	end

	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
		total_checks++;
		if (seen_v !== exp_v) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clock);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock); while (bvalid !== 1'b1);
		rs = bresp;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] rs;
		axi_write(a, v, rs);
		check({30'h0, rs}, {30'h0, bridge_corr_pkg::RESP_OKAY});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_v);
		logic [31:0] v;
		logic [1:0] rs;
		axi_read(a, v, rs);
		check(v, exp_v);
	endtask

	function automatic logic [7:0] ca(input logic [3:0] i);
		return {bridge_corr_pkg::COEF_REGION, i, 2'b00};
	endfunction

	// Busy probe needs a slow converter so the second command lands mid-measurement
	task automatic meas(input logic [7:0] op, input logic [15:0] word, input logic [7:0] oaddr,
		input logic [31:0] exp_v, input logic sat, input logic [16:0] exp_seen, input bit probe);
		logic [1:0] rs;
		logic [31:0] v;
		axi_write(bridge_corr_pkg::ADDR_CMD, {8'h00, op, word}, rs);
		check({30'h0, rs}, {30'h0, bridge_corr_pkg::RESP_OKAY});
		if (probe) begin
			axi_write(bridge_corr_pkg::ADDR_CMD, {8'h00, op, word}, rs);
			check({30'h0, rs}, {30'h0, bridge_corr_pkg::RESP_SLVERR});
			rd_chk(bridge_corr_pkg::ADDR_STATUS, 32'h0000_0002);
		end
		do @(posedge clock); while (done !== 1'b1);
		axi_read(oaddr, v, rs);
		check(v, exp_v);
		rd_chk(bridge_corr_pkg::ADDR_STATUS, {31'h0, sat});
		check({15'h0, seen}, {15'h0, exp_seen});
		$display("test op %h word %h done", op, word);
	endtask

	initial begin
		rst_b = 1'b0;
		// Response channels stay ready, so back-to-back tasks never toggle them in one step
		{awvalid, wvalid, bready, arvalid, rready} = 5'h05;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		dly = 8'h02;
		b_raw = 18'h00000;
		t_raw = 18'h00000;
		cv = '{32'h8000, 32'h0100, 32'h8000, 32'h4000, 32'h0, 32'h0, 32'h0, 32'h8000, 32'h0,
			32'h0, 32'h0800};
		pb = '{18'h3FF00, 18'h02000, 18'h3DF00};
		pe = '{32'h0000_8000, 32'h0000_A541, 32'h0000_5C00};
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rd_chk(bridge_corr_pkg::ADDR_STATUS, 32'h0000_0000);
		rd_chk(bridge_corr_pkg::ADDR_CTRL, 32'h0000_0000);
		rd_chk(bridge_corr_pkg::ADDR_BM_CFG, {16'h0000, bridge_corr_pkg::BM_CFG_RST});
		axi_read(8'h3C, d, r);
		check(d, 32'h0000_0000);
		check({30'h0, r}, {30'h0, bridge_corr_pkg::RESP_SLVERR});
		axi_write(8'hF0, 32'h1234_5678, r);
		check({30'h0, r}, {30'h0, bridge_corr_pkg::RESP_SLVERR});
		$display("test reset and map done");
		wr(ca(bridge_corr_pkg::CI_GAIN_B), 32'h0003_0000);
		rd_chk(ca(bridge_corr_pkg::CI_GAIN_B), 32'h0001_FFFF);
		wr(ca(bridge_corr_pkg::CI_GAIN_B), 32'hFFFD_0000);
		rd_chk(ca(bridge_corr_pkg::CI_GAIN_B), 32'hFFFE_0001);
		wr(ca(bridge_corr_pkg::CI_OFFSET_T), 32'h0000_5000);
		rd_chk(ca(bridge_corr_pkg::CI_OFFSET_T), 32'h0000_1FFF);
		wr(ca(bridge_corr_pkg::CI_TSETL), 32'h0001_2345);
		rd_chk(ca(bridge_corr_pkg::CI_TSETL), 32'h0000_FFFF);
		axi_write(bridge_corr_pkg::ADDR_CMD, 32'h00A2_0001, r);
		check({30'h0, r}, {30'h0, bridge_corr_pkg::RESP_SLVERR});
		axi_write(bridge_corr_pkg::ADDR_CMD, 32'h0055_0000, r);
		check({30'h0, r}, {30'h0, bridge_corr_pkg::RESP_SLVERR});
		$display("test clamps and refusals done");
		for (int i = 0; i < 11; i++) begin
			wr(ca(i[3:0]), cv[i]);
		end
		wr(bridge_corr_pkg::ADDR_TM_CFG, 32'h0000_1357);
		wr(bridge_corr_pkg::ADDR_BM_CFG, 32'h0000_0ABC);
		t_raw <= 18'h01000;
		dly <= 8'h14;
		meas(8'hA6, 16'h0000, bridge_corr_pkg::ADDR_TEMP_OUT, 32'h9000, 1'b0, 17'h11357, 1);
		rd_chk(bridge_corr_pkg::ADDR_RAW_TEMP, 32'h0000_1000);
		dly <= 8'h00;
		meas(8'hA7, 16'hBEEF, bridge_corr_pkg::ADDR_TEMP_OUT, 32'h9000, 1'b0, 17'h1BEEF, 0);
		b_raw <= 18'h02000;
		meas(8'hA2, 16'h0000, bridge_corr_pkg::ADDR_BRIDGE_OUT, 32'hA750, 1'b0, 17'h00ABC, 0);
		wr(ca(bridge_corr_pkg::CI_OFFSET_B), 32'h0001_FFFF);
		b_raw <= 18'h1FFFF;
		meas(8'hA3, 16'h1234, bridge_corr_pkg::ADDR_BRIDGE_OUT, 32'hFFFF, 1'b1, 17'h01234, 0);
		wr(ca(bridge_corr_pkg::CI_OFFSET_B), 32'h0000_0100);
		b_raw <= 18'h02000;
		dly <= 8'h14;
		meas(8'hA2, 16'h0000, bridge_corr_pkg::ADDR_BRIDGE_OUT, 32'hA750, 1'b0, 17'h00ABC, 1);
		wr(bridge_corr_pkg::ADDR_CTRL, 32'h0000_0001);
		wr(ca(bridge_corr_pkg::CI_TCG), 32'h0000_0000);
		wr(ca(bridge_corr_pkg::CI_TCO), 32'h0000_0000);
		wr(ca(bridge_corr_pkg::CI_BRIDGE_SQ), 32'h0000_4000);
		dly <= 8'h03;
		meas(8'hA2, 16'h0000, bridge_corr_pkg::ADDR_BRIDGE_OUT, 32'hA541, 1'b0, 17'h00ABC, 0);
		b_raw <= 18'h3DF00;
		meas(8'hA2, 16'h0000, bridge_corr_pkg::ADDR_BRIDGE_OUT, 32'h5C00, 1'b0, 17'h00ABC, 0);
		// Seven pairs over seven temperatures and three bridge values, as a calibration pass
		for (int i = 0; i < 7; i++) begin
			t_raw <= 18'(i * 32'h1000);
			meas(8'hA6, 16'h0000, bridge_corr_pkg::ADDR_TEMP_OUT, 32'(32'h8000 + i * 32'h1000),
				1'b0, 17'h11357, 0);
			b_raw <= pb[i % 3];
			meas(8'hA2, 16'h0000, bridge_corr_pkg::ADDR_BRIDGE_OUT, pe[i % 3], 1'b0, 17'h00ABC,
				0);
		end
		tally_and_finish;
	end
endmodule // bridge_temp_correction_tb
